// ---- design/bmff_top.sv ----
// bridge mode selection, fault latches, open-drain flags and registers
// ==========================================
`timescale 1ns/10ps
module bmff_top import bmff_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   // detector levels and pins
   input wire logic thermal_shutdown,
   input wire logic overcurrent_detect,
   input wire logic motor_supply_low,
   input wire logic angle_reset,
   input wire logic chop_timing_pin,
   // sequencer
   input wire logic step_pulse,
   input wire logic step_dir,
   input wire logic [1:0] current_dir,
   // bridge gates, channel a then b
   output logic [1:0][3:0] bridge_gates,
   // open-drain flags
   output logic angle_home_flag_drv,
   output logic angle_home_flag_en,
   output logic combined_fault_flag_drv,
   output logic combined_fault_flag_en,
   output logic thermal_fault_flag_drv,
   output logic thermal_fault_flag_en
);
   typedef struct packed {
      logic [4:0] sy1;
      logic [4:0] sy2;
      logic [7:0] ctrl;
      logic [3:0] chg;
      logic [3:0] mask;
      logic [3:0] stat;
      logic tsd_l;
      logic isd_l;
      logic lo1;
      logic uv_q;
      logic [ANGLE_W-1:0] angle;
      logic home;
      logic [7:0] rdata;
   } bmff_top_s;

   localparam bmff_top_s RST_S = '{
      sy1: 5'h00,
      sy2: 5'h00,
      ctrl: CTRL_RST,
      chg: CHG_RST,
      mask: MASK_RST,
      stat: 4'h0,
      tsd_l: 1'b0,
      isd_l: 1'b0,
      lo1: 1'b0,
      uv_q: 1'b0,
      angle: ANGLE_HOME,
      home: 1'b1,
      rdata: 8'h00
   };

   bmff_top_s r;
   bmff_top_s n;
   logic uv;
   logic clr;
   logic kill;
   logic [3:0] phase;

   // ==========================================
   // fault summary
   assign uv = r.sy2[SY_UV];
   // a low supply is treated as the supply going away, so it releases
   assign clr = r.ctrl[C_SLEEP] | uv;
   assign kill = r.tsd_l | r.isd_l | uv | r.ctrl[C_SLEEP];

   // ==========================================
   // chopping timebase
   bmff_chop u_chop (
      .clk(clk),
      .sys_rst(sys_rst),
      .ext_osc(r.sy2[SY_RES]),
      .phase(phase)
   );

   // ==========================================
   // channels: charge first in each period, then the chosen decay
   genvar i;
   for (i = 0; i < 2; i++) begin : g_ch
      bmff_ch_if ch ();
      always_comb begin
         if (kill || !r.ctrl[C_EN_A + i]) begin
            ch.mode = BMFF_OFF;
         end else if (phase < r.chg) begin
            ch.mode = BMFF_CHARGE;
         end else if (r.ctrl[C_SLOW_A + i]) begin
            ch.mode = BMFF_SLOW;
         end else begin
            ch.mode = BMFF_FAST;
         end
      end
      assign ch.dir = current_dir[i];
      bmff_bridge u_brg (
         .clk(clk),
         .sys_rst(sys_rst),
         .ch(ch.brg)
      );
      assign bridge_gates[i] = ch.gates;
   end

   // ==========================================
   // next state
   always_comb begin
      logic [3:0] ev;
      logic [3:0] wclr;
      ev = 4'h0;
      wclr = 4'h0;
      n = r;
      // pins pass two flops before use
      n.sy1 = {chop_timing_pin, angle_reset, motor_supply_low,
         overcurrent_detect, thermal_shutdown};
      n.sy2 = r.sy1;
      n.uv_q = uv;

      // detection sets win over the release
      n.tsd_l = r.sy2[SY_TSD] | (r.tsd_l & ~clr);
      n.isd_l = r.sy2[SY_ISD] | (r.isd_l & ~clr);
      n.lo1 = n.tsd_l | n.isd_l;

      // electrical angle
      if (r.sy2[SY_ARST]) begin
         n.angle = ANGLE_HOME;
      end else if (step_pulse) begin
         if (step_dir) begin
            n.angle = r.angle - 7'h01;
         end else begin
            n.angle = r.angle + 7'h01;
         end
      end
      n.home = (n.angle == ANGLE_HOME);

      // events
      ev[E_TSD] = n.tsd_l & ~r.tsd_l;
      ev[E_ISD] = n.isd_l & ~r.isd_l;
      ev[E_UV] = uv & ~r.uv_q;
      ev[E_HOME] = n.home & ~r.home;

      // writes
      if (reg_wr) begin
         if (reg_addr == A_CTRL) begin
            n.ctrl = reg_wdata & CTRL_MASK;
         end else if (reg_addr == A_CHG) begin
            n.chg = reg_wdata[3:0];
         end else if (reg_addr == A_STAT) begin
            wclr = reg_wdata[3:0];
         end else if (reg_addr == A_MASK) begin
            n.mask = reg_wdata[3:0];
         end
      end
      // an event in the clearing cycle stays set
      n.stat = (r.stat & ~wclr) | ev;

      // reads: data valid only in the cycle after the strobe
      n.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == A_CTRL) begin
            n.rdata = r.ctrl;
         end else if (reg_addr == A_CHG) begin
            n.rdata = {4'h0, r.chg};
         end else if (reg_addr == A_STAT) begin
            n.rdata = {4'h0, r.stat};
         end else if (reg_addr == A_MASK) begin
            n.rdata = {4'h0, r.mask};
         end else if (reg_addr == A_FLAG) begin
            n.rdata = {4'h0, r.sy2[SY_RES], uv, r.isd_l, r.tsd_l};
         end else if (reg_addr == A_ANGLE) begin
            n.rdata = {1'b0, r.angle};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= RST_S;
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // outputs
   assign reg_rdata = r.rdata;
   assign irq = |(r.stat & r.mask);
   // open drain: the level is always low, only the enable moves
   assign angle_home_flag_drv = 1'b0;
   assign combined_fault_flag_drv = 1'b0;
   assign thermal_fault_flag_drv = 1'b0;
   assign angle_home_flag_en = r.home;
   assign combined_fault_flag_en = r.lo1;
   assign thermal_fault_flag_en = r.tsd_l;

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_tsd_hit;
      !r.tsd_l && r.sy2[SY_TSD];
   endsequence
   sequence s_isd_only;
      !r.tsd_l && r.sy2[SY_ISD] && !r.sy2[SY_TSD];
   endsequence
   sequence s_released;
      clr && !r.sy2[SY_TSD] && !r.sy2[SY_ISD];
   endsequence

   chk_home_level: assert property (angle_home_flag_en == (r.angle == ANGLE_HOME))
      else $error("home flag does not follow the angle");
   chk_flags_od: assert property (!angle_home_flag_drv &&
      !combined_fault_flag_drv && !thermal_fault_flag_drv)
      else $error("open-drain flag driven high");
   chk_lo1_idle: assert property (!r.tsd_l && !r.isd_l |-> !combined_fault_flag_en)
      else $error("combined fault flag low without fault");
   chk_tsd_flags: assert property (s_tsd_hit |=>
      combined_fault_flag_en && thermal_fault_flag_en)
      else $error("thermal fault did not pull both flags");
   chk_isd_flags: assert property (s_isd_only |=>
      combined_fault_flag_en && !thermal_fault_flag_en)
      else $error("overcurrent flag pattern wrong");
   chk_latch_hold: assert property (r.lo1 && !clr |=> r.lo1)
      else $error("fault flag released without sleep or supply loss");
   chk_latch_free: assert property (s_released |=> !r.lo1 ##0 !thermal_fault_flag_en)
      else $error("fault flag not released");
   chk_angle_reset: assert property (r.sy2[SY_ARST] |=> r.angle == ANGLE_HOME)
      else $error("angle reset did not reach home");
   chk_fault_off: assert property (kill |=> bridge_gates == '0)
      else $error("bridge not off under fault");
   chk_three_modes: assert property (!kill && r.ctrl[C_EN_A] |->
      g_ch[0].ch.mode != BMFF_OFF)
      else $error("enabled channel left without a regulating state");
   chk_rd_late: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule : bmff_top

// ---- design/bmff_pkg.sv ----
// shared constants and types of the bridge mode and fault flag block
package bmff_pkg;
   // ==========================================
   // timing
   localparam int CLK_NS = 100;
   localparam int CLK_KHZ = 10000;
   localparam int OSC_INT_KHZ = 914;
   localparam int CHOP_DIV = 16;
   localparam int DEAD_NS = 200;
   localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
   // ==========================================
   // gate bit positions
   localparam int G_HA = 0;
   localparam int G_HB = 1;
   localparam int G_LA = 2;
   localparam int G_LB = 3;
   typedef enum logic [1:0] {
      BMFF_OFF = 2'b00,
      BMFF_CHARGE = 2'b01,
      BMFF_FAST = 2'b10,
      BMFF_SLOW = 2'b11
   } bmff_mode_e;
   // ==========================================
   // register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CHG = 8'h01;
   localparam logic [7:0] A_STAT = 8'h02;
   localparam logic [7:0] A_MASK = 8'h03;
   localparam logic [7:0] A_FLAG = 8'h04;
   localparam logic [7:0] A_ANGLE = 8'h05;
   // ==========================================
   // fields and reset values
   localparam int C_SLEEP = 0;
   localparam int C_EN_A = 1;
   localparam int C_SLOW_A = 3;
   localparam logic [7:0] CTRL_MASK = 8'h1F;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] CHG_RST = 4'h8;
   localparam logic [3:0] MASK_RST = 4'h0;
   localparam int E_TSD = 0;
   localparam int E_ISD = 1;
   localparam int E_UV = 2;
   localparam int E_HOME = 3;
   localparam int SY_TSD = 0;
   localparam int SY_ISD = 1;
   localparam int SY_UV = 2;
   localparam int SY_ARST = 3;
   localparam int SY_RES = 4;
   localparam int ANGLE_W = 7;
   localparam logic [6:0] ANGLE_HOME = 7'h10;

   // ==========================================
   // switch table for one leg pair
   function automatic logic [3:0] bmff_decode(bmff_mode_e m, logic rev);
      logic [3:0] g;
      g = 4'h0;
      case (m)
         BMFF_CHARGE: g = rev ? 4'h6 : 4'h9;
         BMFF_FAST: g = rev ? 4'h9 : 4'h6;
         BMFF_SLOW: g = 4'hC;
         default: g = 4'h0;
      endcase
      return g;
   endfunction : bmff_decode
endpackage : bmff_pkg

// ---- design/bmff_ch_if.sv ----
// request and gate bundle between the top and one bridge sequencer
`timescale 1ns/10ps
interface bmff_ch_if;
   import bmff_pkg::*;
   bmff_mode_e mode;
   logic dir;
   logic [3:0] gates;
   modport ctl (output mode, output dir, input gates);
   modport brg (input mode, input dir, output gates);
endinterface : bmff_ch_if

// ---- design/bmff_chop.sv ----
// chopping oscillator select and divide-by-16 phase counter
`timescale 1ns/10ps
module bmff_chop import bmff_pkg::*; #(
   parameter int OSC_KHZ = OSC_INT_KHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // resistor fitted on the timing pin
   input wire logic ext_osc,
   // chopping phase
   output logic [3:0] phase
);
   localparam logic [13:0] INC = 14'(OSC_KHZ);
   localparam logic [13:0] LIM = 14'(CLK_KHZ);
   typedef struct packed {
      logic [13:0] acc;
      logic tick;
      logic [3:0] phase;
   } bmff_chop_s;
   bmff_chop_s r;
   bmff_chop_s n;

   if (OSC_KHZ < 1 || OSC_KHZ >= CLK_KHZ || CHOP_DIV != 16) begin : g_bad
      $error("bmff_chop: oscillator rate not served");
   end

   // ==========================================
   // oscillator: external resistor runs at clock rate, else fractional ticks
   always_comb begin
      logic [13:0] sum;
      sum = r.acc + INC;
      n = r;
      if (ext_osc) begin
         n.tick = 1'b1;
         n.acc = 14'h0000;
      end else if (sum >= LIM) begin
         n.tick = 1'b1;
         n.acc = sum - LIM;
      end else begin
         n.tick = 1'b0;
         n.acc = sum;
      end
      if (r.tick) begin
         n.phase = r.phase + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign phase = r.phase;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_int_rate: assert property (!ext_osc && r.tick |=> !r.tick)
      else $error("internal oscillator ticked twice in a row");
   chk_phase_wrap: assert property (r.tick && r.phase == 4'hF |=> r.phase == 4'h0)
      else $error("chopping phase did not wrap after 16 ticks");
endmodule : bmff_chop

// ---- design/bmff_bridge.sv ----
// one h-bridge: mode to switch states with dead time between changes
`timescale 1ns/10ps
module bmff_bridge import bmff_pkg::*; #(
   parameter int DEAD = DEAD_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // channel request and gates
   bmff_ch_if.brg ch
);
   typedef struct packed {
      bmff_mode_e mode;
      logic dir;
      logic [3:0] cnt;
      logic [3:0] gates;
   } bmff_brg_s;
   localparam bmff_brg_s RST_S = '{BMFF_OFF, 1'b0, 4'(DEAD), 4'h0};
   bmff_brg_s r;
   bmff_brg_s n;

   if (DEAD < 1 || DEAD > 15) begin : g_bad
      $error("bmff_bridge: dead time out of range");
   end

   // ==========================================
   // off is immediate; any other change first opens every switch
   always_comb begin
      n = r;
      if (ch.mode == BMFF_OFF) begin
         n = RST_S;
      end else if (ch.mode != r.mode || ch.dir != r.dir) begin
         n.mode = ch.mode;
         n.dir = ch.dir;
         n.cnt = 4'(DEAD);
         n.gates = 4'h0;
      end else if (r.cnt != 4'h0) begin
         n.cnt = r.cnt - 4'h1;
         n.gates = 4'h0;
      end else begin
         n.gates = bmff_decode(r.mode, r.dir);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= RST_S;
      end else begin
         r <= n;
      end
   end

   assign ch.gates = r.gates;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_swap;
      r.gates != 4'h0 ##1 r.gates != $past(r.gates);
   endsequence
   chk_no_shoot: assert property (!(r.gates[G_HA] && r.gates[G_LA]) &&
      !(r.gates[G_HB] && r.gates[G_LB]))
      else $error("both switches of one leg on");
   chk_dead_gap: assert property (s_swap |-> (r.gates == 4'h0) [*2])
      else $error("switch change without dead interval");
   chk_gate_table: assert property (r.gates != 4'h0 |->
      r.gates == bmff_decode(r.mode, r.dir))
      else $error("gates differ from mode table");
endmodule : bmff_bridge

// ---- design/bmff_top_unused.sv ----
// spare file of the bridge mode block: holds no logic

// ---- tb/bmff_winding_model.sv ----
// far-side model: motor windings on the bridges and pull-ups on the flag lines
`timescale 1ns/10ps
module bmff_winding_model (
   // clock
   input wire logic clk,
   // bridge gates and a commanded winding short
   input wire logic [1:0][3:0] gates,
   input wire logic short_cmd,
   // flag drivers and enables: home, combined, thermal
   input wire logic [2:0] drv,
   input wire logic [2:0] en,
   // detector level and resolved flag lines
   output logic overcurrent,
   output logic [2:0] pins
);
   // ==========================================
   // winding
   // a short only draws current while a switch conducts, so the level drops once all are off
   always @(posedge clk) begin
      overcurrent <= short_cmd & (|gates);
   end
   // ==========================================
   // flag lines
   // pull-ups: a released line reads high, never the last driven value
   assign pins = ~en | drv;
endmodule : bmff_winding_model

// ---- tb/bmff_top_tb_top.sv ----
// self-checking bench of the bridge mode and fault flag block
`timescale 1ns/10ps
module bmff_top_tb_top;
   import bmff_pkg::*;
   // ==========================================
   // signals
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [7:0] reg_addr = 8'h0;
   logic [7:0] reg_wdata = 8'h0;
   logic [7:0] reg_rdata;
   logic irq;
   logic thermal_shutdown = 1'h0;
   logic motor_supply_low = 1'h0;
   logic angle_reset = 1'h0;
   logic chop_timing_pin = 1'h1;
   logic step_pulse = 1'h0;
   logic step_dir = 1'h0;
   logic short_cmd = 1'h0;
   logic [1:0] current_dir = 2'h0;
   logic overcurrent_detect;
   logic [1:0][3:0] bridge_gates;
   logic [2:0] drv;
   logic [2:0] en;
   logic [2:0] pins;
   logic [1:0][3:0] prev_g = 8'h0;
   logic [3:0] g;
   int zrun [2] = '{0, 0};
   int failures = 0;
   int num_checks = 0;
   always #(CLK_NS / 2) clk = ~clk;
   bmff_top bmff_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .thermal_shutdown(thermal_shutdown), .overcurrent_detect(overcurrent_detect),
      .motor_supply_low(motor_supply_low), .angle_reset(angle_reset),
      .chop_timing_pin(chop_timing_pin), .step_pulse(step_pulse), .step_dir(step_dir),
      .current_dir(current_dir), .bridge_gates(bridge_gates),
      .angle_home_flag_drv(drv[2]), .angle_home_flag_en(en[2]),
      .combined_fault_flag_drv(drv[1]), .combined_fault_flag_en(en[1]),
      .thermal_fault_flag_drv(drv[0]), .thermal_fault_flag_en(en[0]));
   bmff_winding_model bmff_winding_model_inst (.clk(clk), .gates(bridge_gates),
      .short_cmd(short_cmd), .drv(drv), .en(en), .overcurrent(overcurrent_detect), .pins(pins));
   // ==========================================
   // checking and bus tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
      num_checks++;
      if (v !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      chk(n, e, reg_rdata);
   endtask : rd
   task automatic step(input logic d);
      @(posedge clk);
      step_pulse <= 1'h1;
      step_dir <= d;
      @(posedge clk);
      step_pulse <= 1'h0;
   endtask : step
   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : settle
   // bounded wait until channel a gates equal (eq=1) or differ from (eq=0) v
   task automatic wait_g(input logic [3:0] v, input logic eq, output int n);
      n = 0;
      while (((bridge_gates[0] === v) != eq) && n < 400) begin
         settle(1);
         n++;
      end
   endtask : wait_g
   // one chop period: charge, decay, charge again
   task automatic probe(input logic rev, input logic slw, input int lo, input int hi);
      logic [3:0] cg;
      logic [3:0] dg;
      int n;
      int m;
      cg = rev ? 4'h6 : 4'h9;
      dg = slw ? 4'hC : (rev ? 4'h9 : 4'h6);
      current_dir <= {rev, rev};
      wr(A_CTRL, {3'h0, slw, slw, 3'h6});
      // a direction change restarts the dead gap mid-charge; sync on a decay first
      settle(4);
      wait_g(dg, 1'h1, n);
      wait_g(cg, 1'h1, n);
      wait_g(cg, 1'h0, n);
      wait_g(dg, 1'h1, m);
      chk("decay_gates", {4'h0, dg}, {4'h0, bridge_gates[0]});
      chk("chan_b", {4'h0, bridge_gates[0]}, {4'h0, bridge_gates[1]});
      n = n + m;
      wait_g(cg, 1'h1, m);
      chk("charge_gates", {4'h0, cg}, {4'h0, bridge_gates[0]});
      chk("period", 8'h1, {7'h0, (n + m >= lo) && (n + m <= hi)});
   endtask : probe
   task automatic fault(input logic th);
      int n;
      wr(A_STAT, 8'h0F);
      wr(A_MASK, th ? 8'h03 : 8'h01);
      if (th) thermal_shutdown <= 1'h1;
      else short_cmd <= 1'h1;
      n = 0;
      while (en[1] !== 1'h1 && n < 20) begin
         settle(1);
         n++;
      end
      settle(2);
      chk("comb_flag", 8'h0, {7'h0, pins[1]});
      chk("therm_flag", {7'h0, ~th}, {7'h0, pins[0]});
      chk("gates_off", 8'h0, bridge_gates);
      chk("irq_mask", {7'h0, th}, {7'h0, irq});
      rd(A_STAT, th ? 8'h01 : 8'h02, "stat");
      thermal_shutdown <= 1'h0;
      short_cmd <= 1'h0;
      settle(8);
      chk("latched", {7'h0, ~th}, {6'h0, pins[1:0]});
      wr(A_STAT, 8'h0F);
      settle(1);
      chk("irq_clr", 8'h0, {7'h0, irq});
      if (th) begin
         wr(A_CTRL, 8'h07);
         wr(A_CTRL, 8'h06);
      end else begin
         motor_supply_low <= 1'h1;
         settle(4);
         motor_supply_low <= 1'h0;
      end
      settle(6);
      chk("released", 8'h3, {6'h0, pins[1:0]});
   endtask : fault
   // ==========================================
   // continuous bridge and flag monitor
   always @(posedge clk) begin
      #1;
      chk("flag_drv", 8'h0, {5'h0, drv});
      for (int i = 0; i < 2; i++) begin
         g = bridge_gates[i];
         if (g != 4'h0) begin
            chk("legal", 8'h1, {7'h0, g inside {4'h6, 4'h9, 4'hC}});
            if (prev_g[i] != 4'h0) chk("no_swap", {4'h0, prev_g[i]}, {4'h0, g});
            else chk("dead_run", 8'h1, {7'h0, zrun[i] > DEAD_CYC});
            zrun[i] = 0;
         end else begin
            zrun[i]++;
         end
         prev_g[i] = g;
      end
   end
   // ==========================================
   // main sequence and watchdog
   initial begin
      int k;
      void'($urandom(32'hAFE58BB4));
      settle(4);
      sys_rst <= 1'h0;
      chk("home_rst", 8'h0, {7'h0, pins[2]});
      chk("flags_rst", 8'h3, {6'h0, pins[1:0]});
      rd(A_CTRL, CTRL_RST, "ctrl");
      rd(A_CHG, {4'h0, CHG_RST}, "chg");
      rd(A_MASK, {4'h0, MASK_RST}, "mask");
      wr(8'h3F, 8'hFF);
      rd(8'h3F, 8'h00, "unmapped");
      rd(A_CTRL, CTRL_RST, "ctrl_kept");
      k = $urandom_range(6, 1);
      repeat (k) step(1'h0);
      settle(3);
      chk("home_away", 8'h1, {7'h0, pins[2]});
      rd(A_ANGLE, {1'h0, ANGLE_HOME} + 8'(k), "angle");
      repeat (k) step(1'h1);
      settle(3);
      chk("home_back", 8'h0, {7'h0, pins[2]});
      repeat (3) step(1'h0);
      angle_reset <= 1'h1;
      settle(6);
      chk("home_forced", 8'h0, {7'h0, pins[2]});
      step(1'h0);
      settle(4);
      chk("home_held", 8'h0, {7'h0, pins[2]});
      angle_reset <= 1'h0;
      wr(A_CHG, 8'($urandom_range(12, 4)));
      for (int r = 0; r < 2; r++) begin
         for (int s = 0; s < 2; s++) probe(r[0], s[0], CHOP_DIV, CHOP_DIV);
      end
      chop_timing_pin <= 1'h0;
      probe(1'($urandom_range(1, 0)), 1'h0, 174, 177);
      chop_timing_pin <= 1'h1;
      fault(1'h1);
      fault(1'h0);
      tally_and_finish();
   end
   initial begin
      #(30000 * CLK_NS);
      failures++;
      tally_and_finish();
   end
endmodule : bmff_top_tb_top
